// ---- common/mtc_pkg.sv ----
package mtc_pkg;
	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_XLATE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DATA_WINDOW0 = 8'h04;
	localparam logic [7:0] ADDR_DATA_WINDOW1 = 8'h08;
	localparam logic [7:0] ADDR_INSTR_WINDOW0 = 8'h0c;
	localparam logic [7:0] ADDR_INSTR_WINDOW1 = 8'h10;
	localparam logic [7:0] ADDR_PROBE_STATUS = 8'h14;
	// translation control fields
	localparam int CTRL_ENABLE_BIT = 15;
	localparam int CTRL_PAGE_BIT = 14;
	localparam logic [15:0] CTRL_IMPL_MASK = 16'hc000;
	localparam logic RESET_CTRL_ENABLE = 1'b0;
	// window fields
	localparam logic [31:0] WINDOW_IMPL_MASK = 32'hffffe364;
	localparam int WIN_BASE_HI = 31;
	localparam int WIN_MASK_HI = 23;
	localparam int WIN_ENABLE_BIT = 15;
	localparam int WIN_PRIV_HI = 14;
	localparam int WIN_UATTR_HI = 9;
	localparam int WIN_CMODE_HI = 6;
	localparam int WIN_WPROT_BIT = 2;
	localparam logic [31:0] RESET_WINDOW = 32'h00000000;
	// probe status fields
	localparam int STAT_BUS_ERR_BIT = 11;
	localparam int STAT_HIT_BIT = 1;
	localparam int STAT_RES_BIT = 0;
	localparam logic [31:0] STAT_IMPL_MASK = 32'hfffffff7;
	localparam logic [31:0] RESET_STATUS = 32'h00000000;
	// cache modes
	typedef enum logic [1:0] {
		MTC_CM_WTHRU = 2'b00,
		MTC_CM_COPYBACK = 2'b01,
		MTC_CM_NC_SERIAL = 2'b10,
		MTC_CM_NC = 2'b11
	} mtc_cmode_t;
	// one access from the integer unit
	typedef struct packed {
		logic [31:0] laddr;
		logic priv;
		logic is_instr;
		logic is_write;
		logic ext_bus;
	} mtc_access_t;
	// attributes handed to the cache and bus logic
	typedef struct packed {
		logic [31:0] paddr;
		logic [1:0] cmode;
		logic wprot_abort;
		logic window_hit;
		logic xlate_used;
		logic uattr_lo;
		logic uattr_hi;
	} mtc_attr_t;
	// result of one table search for the probe instruction
	typedef struct packed {
		logic bus_err;
		logic valid;
		logic [19:0] frame;
		logic global_bit;
		logic [1:0] uattr;
		logic superv;
		logic [1:0] cmode;
		logic modified;
		logic any_wprot;
	} mtc_walk_t;
endpackage

// ---- design/mtc_top.sv ----
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - control bit 15 enables paging, reset clears
// - paging off passes logical address unchanged
// - off and no hit: write-through, unprotected, zero attrs
// - purge works in any enable state
// - bit 14 selects 4k or 8k pages
// - control low bits read zero, word access
// - window unimplemented bits read zero
// - windows ignore paging enable and kill pin
// - base bits 31:24 compared with address
// - mask bits drop base bits from compare
// - window bit 15 enables the window
// - privilege field: user, supervisor or either
// - window user bits drive attribute outputs on external bus accesses
// - cache mode field selects access treatment
// - write protect aborts writes, permits reads
// - probe loads frame address into top bits
// - search transfer error sets only bit 11
// - descriptor indications copied into probe status
// - any level write protect sets status bit
// - probe window hit sets bits 1 and 0
// - resident on window hit or valid page
module mtc_top (
	// apb slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// access from the integer unit, same clock
	input wire mtc_pkg::mtc_access_t acc,
	input wire logic [19:0] xlate_frame,
	input wire logic [1:0] xlate_cmode,
	input wire logic xlate_wprot,
	// external translation disable pin
	input wire logic xlate_kill_pin,
	// probe instruction and search result
	input wire logic probe_instr,
	input wire mtc_pkg::mtc_walk_t probe_walk,
	input wire logic xlate_purge_instr,
	// results to cache and bus logic
	output mtc_pkg::mtc_attr_t attr,
	output logic user_attr_out_lo,
	output logic user_attr_out_hi,
	output logic xlate_purge_go,
	output logic xlate_on,
	output logic page_8k
);
	logic [15:0] xlate_ctrl;
	logic ctrl_en;
	logic ctrl_pg;
	logic [31:0] win [4];
	logic [31:0] probe_status;
	logic [2:0] kill_sync;
	logic kill_q;
	logic [3:0] hit_vec;
	logic [3:0] probe_hit_vec;
	logic [31:0] next_status;
	mtc_pkg::mtc_attr_t next_attr;
	logic [1:0] hit_idx;
	logic any_hit;
	logic acc_q;
	logic wr_en;
	logic rd_en;

	// one match test, shared by the access path and the probe path
	function automatic logic win_match(input logic [31:0] w, input logic [31:0] la,
			input logic pr);
		logic [7:0] care;
		logic base_ok;
		logic priv_ok;
		care = ~w[mtc_pkg::WIN_MASK_HI -: 8];
		base_ok = ((w[mtc_pkg::WIN_BASE_HI -: 8] ^ la[31:24]) & care) == 8'h00;
		priv_ok = w[mtc_pkg::WIN_PRIV_HI] | (w[mtc_pkg::WIN_PRIV_HI - 1] == pr);
		win_match = w[mtc_pkg::WIN_ENABLE_BIT] & base_ok & priv_ok;
	endfunction

	// register decode used by both read and write paths
	function automatic logic [2:0] reg_index(input logic [7:0] a);
		case (a)
			mtc_pkg::ADDR_XLATE_CTRL: reg_index = 3'h0;
			mtc_pkg::ADDR_DATA_WINDOW0: reg_index = 3'h1;
			mtc_pkg::ADDR_DATA_WINDOW1: reg_index = 3'h2;
			mtc_pkg::ADDR_INSTR_WINDOW0: reg_index = 3'h3;
			mtc_pkg::ADDR_INSTR_WINDOW1: reg_index = 3'h4;
			mtc_pkg::ADDR_PROBE_STATUS: reg_index = 3'h5;
			default: reg_index = 3'h7;
		endcase
	endfunction

	// apb answers with one wait state, because pready is registered
	assign wr_en = psel & penable & pwrite & ~pready;
	assign rd_en = psel & penable & ~pwrite & ~pready;

	// kill pin resynchroniser; only stages two and three are looked at
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			kill_sync <= 3'h0;
			kill_q <= 1'b0;
		end else begin
			kill_sync <= {kill_sync[1:0], xlate_kill_pin};
			if (kill_sync[1] == kill_sync[2]) begin
				kill_q <= kill_sync[2];
			end
		end
	end

	// translation enable; page bit kept in its own flop, outside reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en <= mtc_pkg::RESET_CTRL_ENABLE;
		end else if (wr_en && reg_index(paddr) == 3'h0) begin
			ctrl_en <= pwdata[mtc_pkg::CTRL_ENABLE_BIT];
		end
	end

	// page size has no reset: software must load it before use
	always_ff @(posedge pclk) begin
		if (wr_en && reg_index(paddr) == 3'h0) begin
			ctrl_pg <= pwdata[mtc_pkg::CTRL_PAGE_BIT];
		end
	end

	// only the two control bits exist; one driver for the whole word
	assign xlate_ctrl = {ctrl_en, ctrl_pg, 14'h0000} & mtc_pkg::CTRL_IMPL_MASK;

	// window registers; unimplemented bits never stored
	generate
		for (genvar i = 0; i < 4; i++) begin : g_win
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					win[i] <= mtc_pkg::RESET_WINDOW;
				end else if (wr_en && reg_index(paddr) == 3'(i + 1)) begin
					win[i] <= pwdata & mtc_pkg::WINDOW_IMPL_MASK;
				end
			end
			// accesses: data windows 0,1 only for data, instr windows 2,3 only for fetches; the probe path tests all four
			assign hit_vec[i] = win_match(win[i], acc.laddr, acc.priv) &
				((i >= 2) == acc.is_instr);
			assign probe_hit_vec[i] = win_match(win[i], acc.laddr, acc.priv);
		end
	endgenerate

	// lowest numbered hit wins when windows overlap
	always_comb begin
		hit_idx = 2'h0;
		any_hit = |hit_vec;
		for (int j = 3; j >= 0; j--) begin
			if (hit_vec[j]) begin
				hit_idx = 2'(j);
			end
		end
	end

	// attribute selection for one access
	always_comb begin
		next_attr = '0;
		next_attr.paddr = acc.laddr;
		next_attr.cmode = mtc_pkg::MTC_CM_WTHRU;
		if (any_hit) begin
			next_attr.window_hit = 1'b1;
			next_attr.cmode = win[hit_idx][mtc_pkg::WIN_CMODE_HI -: 2];
			next_attr.wprot_abort = win[hit_idx][mtc_pkg::WIN_WPROT_BIT] &
				acc.is_write;
			next_attr.uattr_hi = win[hit_idx][mtc_pkg::WIN_UATTR_HI] & acc.ext_bus;
			next_attr.uattr_lo = win[hit_idx][mtc_pkg::WIN_UATTR_HI - 1] & acc.ext_bus;
		end else if (xlate_ctrl[mtc_pkg::CTRL_ENABLE_BIT] && !kill_q) begin
			// paged path: frame supplied by the translation cache
			next_attr.xlate_used = 1'b1;
			next_attr.paddr = xlate_ctrl[mtc_pkg::CTRL_PAGE_BIT] ?
				{xlate_frame[19:1], acc.laddr[12:0]} : {xlate_frame, acc.laddr[11:0]};
			next_attr.cmode = xlate_cmode;
			next_attr.wprot_abort = xlate_wprot & acc.is_write;
		end
	end

	// registered outputs to the cache and bus logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			attr <= '0;
			user_attr_out_lo <= 1'b0;
			user_attr_out_hi <= 1'b0;
			xlate_on <= 1'b0;
			page_8k <= 1'b0;
			xlate_purge_go <= 1'b0;
		end else begin
			attr <= next_attr;
			user_attr_out_lo <= next_attr.uattr_lo;
			user_attr_out_hi <= next_attr.uattr_hi;
			xlate_on <= xlate_ctrl[mtc_pkg::CTRL_ENABLE_BIT] & ~kill_q;
			page_8k <= xlate_ctrl[mtc_pkg::CTRL_PAGE_BIT];
			xlate_purge_go <= xlate_purge_instr;
		end
	end

	// probe status content for one probe
	always_comb begin
		next_status = '0;
		if (|probe_hit_vec) begin
			next_status[mtc_pkg::STAT_HIT_BIT] = 1'b1;
			next_status[mtc_pkg::STAT_RES_BIT] = 1'b1;
		end else if (probe_walk.bus_err) begin
			next_status[mtc_pkg::STAT_BUS_ERR_BIT] = 1'b1;
		end else begin
			next_status[31:12] = probe_walk.frame;
			next_status[10] = probe_walk.global_bit;
			next_status[9:8] = probe_walk.uattr;
			next_status[7] = probe_walk.superv;
			next_status[6:5] = probe_walk.cmode;
			next_status[4] = probe_walk.modified;
			next_status[2] = probe_walk.any_wprot;
			next_status[mtc_pkg::STAT_RES_BIT] = probe_walk.valid;
		end
	end

	// probe result beats a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			probe_status <= mtc_pkg::RESET_STATUS;
		end else if (probe_instr) begin
			probe_status <= next_status;
		end else if (wr_en && reg_index(paddr) == 3'h5) begin
			probe_status <= pwdata & mtc_pkg::STAT_IMPL_MASK;
		end
	end

	// apb handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & (reg_index(paddr) == 3'h7);
			if (rd_en) begin
				case (reg_index(paddr))
					3'h0: prdata <= {16'h0000, xlate_ctrl};
					3'h1: prdata <= win[0];
					3'h2: prdata <= win[1];
					3'h3: prdata <= win[2];
					3'h4: prdata <= win[3];
					3'h5: prdata <= probe_status;
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// reset and translation enable
	enable_reset_a: assert property (@(posedge pclk) $rose(presetn) |->
		!xlate_ctrl[mtc_pkg::CTRL_ENABLE_BIT]) else $error("enable not cleared by reset");
	reset_quiet_a: assert property (@(posedge pclk) !presetn |->
		(attr == '0 && !xlate_on && !pready && !xlate_purge_go))
		else $error("outputs not quiet in reset");
	enable_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && reg_index(paddr) == 3'h0) |=>
		xlate_ctrl[mtc_pkg::CTRL_ENABLE_BIT] == $past(pwdata[mtc_pkg::CTRL_ENABLE_BIT]))
		else $error("enable write lost");
	xlate_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(xlate_ctrl[mtc_pkg::CTRL_ENABLE_BIT] && !kill_q) |=> xlate_on)
		else $error("translation on not shown");

	// pass-through and default attributes while paging is off
	pass_thru_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!xlate_ctrl[mtc_pkg::CTRL_ENABLE_BIT] && !xlate_on) |=> attr.paddr == $past(acc.laddr))
		else $error("address not passed through");
	kill_thru_a: assert property (@(posedge pclk) disable iff (!presetn)
		kill_q |=> attr.paddr == $past(acc.laddr))
		else $error("kill pin did not stop translation");
	default_attr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!next_attr.xlate_used && !any_hit) |=> (attr.cmode == 2'b00 && !attr.wprot_abort &&
		!user_attr_out_lo && !user_attr_out_hi)) else $error("default attributes wrong");

	// page size picks how many offset bits bypass the frame
	page_8k_a: assert property (@(posedge pclk) disable iff (!presetn)
		(next_attr.xlate_used && xlate_ctrl[mtc_pkg::CTRL_PAGE_BIT]) |=>
		attr.paddr == {$past(xlate_frame[19:1]), $past(acc.laddr[12:0])})
		else $error("8k page address wrong");
	page_4k_a: assert property (@(posedge pclk) disable iff (!presetn)
		(next_attr.xlate_used && !xlate_ctrl[mtc_pkg::CTRL_PAGE_BIT]) |=>
		attr.paddr == {$past(xlate_frame), $past(acc.laddr[11:0])})
		else $error("4k page address wrong");

	// register read-back of unimplemented bits
	ctrl_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && !pwrite && reg_index(paddr) == 3'h0) |-> prdata[13:0] == 14'h0000)
		else $error("control low bits not zero");
	win_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		((win[0] | win[1] | win[2] | win[3]) & ~mtc_pkg::WINDOW_IMPL_MASK) == 32'h0)
		else $error("window reserved set");

	// window match terms, shown on window zero and on the type split
	win_kill_a: assert property (@(posedge pclk) disable iff (!presetn)
		(kill_q && |hit_vec) |=> (attr.window_hit && !attr.xlate_used))
		else $error("window blocked by kill pin");
	base_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
		hit_vec[0] |-> (((win[0][mtc_pkg::WIN_BASE_HI -: 8] ^ acc.laddr[31:24]) &
		~win[0][mtc_pkg::WIN_MASK_HI -: 8]) == 8'h00))
		else $error("hit on unmasked base miss");
	win_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!win[0][mtc_pkg::WIN_ENABLE_BIT] |-> !hit_vec[0])
		else $error("disabled window hit");
	priv_user_a: assert property (@(posedge pclk) disable iff (!presetn)
		(hit_vec[0] && win[0][mtc_pkg::WIN_PRIV_HI -: 2] == 2'b00) |-> !acc.priv)
		else $error("user window hit by supervisor");
	priv_super_a: assert property (@(posedge pclk) disable iff (!presetn)
		(hit_vec[0] && win[0][mtc_pkg::WIN_PRIV_HI -: 2] == 2'b01) |-> acc.priv)
		else $error("supervisor window hit by user");
	data_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		acc.is_instr |-> !(hit_vec[0] || hit_vec[1]))
		else $error("data window hit by fetch");
	instr_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		!acc.is_instr |-> !(hit_vec[2] || hit_vec[3]))
		else $error("fetch window hit by data");

	// attributes of a window hit
	cmode_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		any_hit |=> attr.cmode == $past(win[hit_idx][mtc_pkg::WIN_CMODE_HI -: 2]))
		else $error("window cache mode not used");
	wprot_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(any_hit && acc.is_write && win[hit_idx][mtc_pkg::WIN_WPROT_BIT]) |=> attr.wprot_abort)
		else $error("protected write not aborted");
	wprot_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		(any_hit && !acc.is_write) |=> !attr.wprot_abort)
		else $error("read aborted");
	uattr_echo_a: assert property (@(posedge pclk) disable iff (!presetn)
		(any_hit && acc.ext_bus) |=>
		user_attr_out_hi == $past(win[hit_idx][mtc_pkg::WIN_UATTR_HI]))
		else $error("user attribute not echoed");
	uattr_lo_a: assert property (@(posedge pclk) disable iff (!presetn)
		(any_hit && acc.ext_bus) |=>
		user_attr_out_lo == $past(win[hit_idx][mtc_pkg::WIN_UATTR_HI - 1]))
		else $error("low user attribute not echoed");
	uattr_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(any_hit && acc.ext_bus) |=> (!user_attr_out_lo && !user_attr_out_hi))
		else $error("user attribute without window bus access");

	// probe status loads
	probe_hit_a: assert property (@(posedge pclk) disable iff (!presetn)
		(probe_instr && |probe_hit_vec) |=> probe_status == 32'h00000003)
		else $error("probe window hit status wrong");
	probe_berr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(probe_instr && !(|probe_hit_vec) && probe_walk.bus_err) |=> probe_status == 32'h00000800)
		else $error("probe bus error status wrong");
	probe_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
		(probe_instr && !(|probe_hit_vec) && !probe_walk.bus_err) |=>
		(probe_status[31:12] == $past(probe_walk.frame) &&
		probe_status[mtc_pkg::STAT_RES_BIT] == $past(probe_walk.valid)))
		else $error("probe frame or resident wrong");
	probe_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		(probe_instr && !(|probe_hit_vec) && !probe_walk.bus_err) |=>
		probe_status[10:2] == {$past(probe_walk.global_bit), $past(probe_walk.uattr),
		$past(probe_walk.superv), $past(probe_walk.cmode), $past(probe_walk.modified), 1'b0,
		$past(probe_walk.any_wprot)})
		else $error("probe descriptor copy wrong");

	// purge echo and apb handshake shape
	purge_a: assert property (@(posedge pclk) disable iff (!presetn)
		xlate_purge_instr |=> xlate_purge_go)
		else $error("purge dropped");
	purge_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!xlate_purge_instr |=> !xlate_purge_go)
		else $error("purge without request");
	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held past one cycle");
	slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error without ready");
endmodule
`default_nettype wire

// ---- tb/mtc_iu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// integer unit stand-in; every request changes just after a rising edge
module mtc_iu_model (
	// clock
	input wire logic pclk,
	// access and its translation-cache lookup
	output mtc_pkg::mtc_access_t acc,
	output logic [19:0] xlate_frame,
	output logic [1:0] xlate_cmode,
	output logic xlate_wprot,
	// probe and purge instructions
	output logic probe_instr,
	output mtc_pkg::mtc_walk_t probe_walk,
	output logic xlate_purge_instr
);
	initial begin
		acc = '0;
		{xlate_frame, xlate_cmode, xlate_wprot, probe_instr, probe_walk, xlate_purge_instr} = '0;
	end
	// one access, held until the next; the lookup result is random noise
	task automatic issue(input mtc_pkg::mtc_access_t a);
		@(posedge pclk);
		acc <= a;
		{xlate_frame, xlate_cmode, xlate_wprot} <= 23'($urandom);
	endtask
	// one-cycle probe pulse; the search result does not linger afterwards
	task automatic probe(input mtc_pkg::mtc_walk_t w);
		@(posedge pclk);
		probe_instr <= 1'b1;
		probe_walk <= w;
		@(posedge pclk);
		probe_instr <= 1'b0;
		probe_walk <= ~w;
	endtask
	// one-cycle purge pulse, issued both with paging off and with paging on
	task automatic purge();
		@(posedge pclk);
		xlate_purge_instr <= 1'b1;
		@(posedge pclk);
		xlate_purge_instr <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// compare one design value with the bench model and count it
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin num_errors++; \
	$display("BAD %0t got %h exp %h", $time, g, x); end end
module tb;
	// bench drives and design results
	logic pclk, presetn, psel, penable, pwrite, kill, pready, pslverr, e;
	logic purge_go, x_on, pg8, wp, probe, purge, ua_lo, ua_hi;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, exp_s;
	logic [19:0] frame;
	logic [1:0] cm;
	logic [15:0] cv [4];
	logic [31:0] win [4];
	mtc_pkg::mtc_access_t acc, a;
	mtc_pkg::mtc_walk_t walk, w;
	mtc_pkg::mtc_attr_t attr;
	int num_errors, total_checks, h, k2;
	bit en, pg;
	mtc_top mtc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .acc(acc), .xlate_frame(frame), .xlate_cmode(cm), .xlate_wprot(wp),
		.xlate_kill_pin(kill), .probe_instr(probe), .probe_walk(walk),
		.xlate_purge_instr(purge), .attr(attr), .user_attr_out_lo(ua_lo),
		.user_attr_out_hi(ua_hi), .xlate_purge_go(purge_go), .xlate_on(x_on), .page_8k(pg8));
	mtc_iu_model mtc_iu_model_inst (.pclk(pclk), .acc(acc), .xlate_frame(frame),
		.xlate_cmode(cm), .xlate_wprot(wp), .probe_instr(probe), .probe_walk(walk),
		.xlate_purge_instr(purge));
	// one apb transfer; the request stays put until pready is seen at an edge
	task automatic apb(input bit wr, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) num_errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read a register, comparing only the bits under the mask
	task automatic rd(input logic [7:0] ad, input logic [31:0] x, input logic [31:0] m);
		apb(1'b0, ad, 32'h0);
		`CHK(r & m, x & m)
	endtask
	// purge and look for its echo one cycle on
	task automatic purge_chk();
		mtc_iu_model_inst.purge();
		@(negedge pclk);
		`CHK(purge_go, 1'b1)
	endtask
	// does window k catch this address and privilege
	function automatic bit hit(int k, logic [31:0] la, logic pv);
		return win[k][15] && (((win[k][31:24] ^ la[31:24]) & ~win[k][23:16]) == 8'h00)
			&& (win[k][14] || win[k][13] == pv);
	endfunction
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// watchdog at 40000 cycles, far beyond the fewer than two thousand cycles the run needs
	initial begin
		#2000000;
		num_errors++;
		end_sim();
	end
	initial begin
		{presetn, psel, penable, pwrite, kill, paddr, pwdata} = '0;
		num_errors = 0;
		total_checks = 0;
		cv = '{16'h0000, 16'h4000, 16'h8000, 16'hc000};
		void'($urandom(47360));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// page bit has no reset value, so it is masked out here
		rd(mtc_pkg::ADDR_XLATE_CTRL, 32'h0, 32'hffffbfff);
		`CHK(x_on, 1'b0)
		apb(1'b0, 8'h18, 32'h0);
		`CHK({e, r}, 33'h100000000)
		purge_chk();
		foreach (cv[i]) begin
			apb(1'b1, mtc_pkg::ADDR_XLATE_CTRL, {16'h0, cv[i]});
			rd(mtc_pkg::ADDR_XLATE_CTRL, {16'h0, cv[i] & 16'hc000}, 32'hffffffff);
			`CHK({x_on, pg8}, cv[i][15:14])
		end
		purge_chk();
		@(posedge pclk);
		kill <= 1'b1;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		`CHK(x_on, 1'b0)
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, mtc_pkg::ADDR_DATA_WINDOW0 + 8'(4 * k), 32'hffffffff);
			rd(mtc_pkg::ADDR_DATA_WINDOW0 + 8'(4 * k), 32'hffffe364, 32'hffffffff);
		end
		// random windows, enable, page size and kill pin, then accesses and a probe
		for (int b = 0; b < 30; b++) begin
			for (int k = 0; k < 4; k++) begin
				win[k] = $urandom & 32'hffffe364;
				win[k][15] = $urandom_range(3) != 0;
				apb(1'b1, mtc_pkg::ADDR_DATA_WINDOW0 + 8'(4 * k), win[k]);
			end
			en = 1'($urandom_range(1));
			pg = 1'($urandom_range(1));
			mtc_iu_model_inst.purge();
			apb(1'b1, mtc_pkg::ADDR_XLATE_CTRL, {16'h0, en, pg, 14'h0});
			kill <= 1'($urandom_range(1));
			for (int i = 0; i < 8; i++) begin
				a = {$urandom, 4'($urandom)};
				k2 = $urandom_range(3);
				if ($urandom_range(1))
					a.laddr[31:24] = win[k2][31:24] ^ (8'($urandom) & win[k2][23:16]);
				mtc_iu_model_inst.issue(a);
				@(posedge pclk);
				@(negedge pclk);
				h = -1;
				for (int j = 3; j >= 0; j--)
					if (j[1] == a.is_instr && hit(j, a.laddr, a.priv)) h = j;
				`CHK(attr.window_hit, 1'(h >= 0))
				if (h >= 0) begin
					`CHK({attr.paddr, attr.cmode}, {a.laddr, win[h][6:5]})
					`CHK(attr.wprot_abort, win[h][2] & a.is_write)
					`CHK({ua_hi, ua_lo}, win[h][9:8] & {2{a.ext_bus}})
				end else if (!en || (i >= 3 && kill)) begin
					`CHK({attr.paddr, attr.cmode, attr.wprot_abort}, {a.laddr, 3'h0})
					`CHK({ua_hi, ua_lo}, 2'h0)
				end else if (i >= 3) begin
					// paged path, once the kill pin has settled through its flops
					exp_s = pg ? {frame[19:1], a.laddr[12:0]} : {frame, a.laddr[11:0]};
					`CHK({attr.xlate_used, attr.paddr}, {1'b1, exp_s})
					`CHK({attr.cmode, attr.wprot_abort}, {cm, wp & a.is_write})
				end
			end
			w = 30'($urandom);
			w.bus_err = $urandom_range(3) == 0;
			mtc_iu_model_inst.issue(a);
			mtc_iu_model_inst.probe(w);
			exp_s = {w.frame, 1'b0, w.global_bit, w.uattr, w.superv, w.cmode, w.modified,
				1'b0, w.any_wprot, 1'b0, w.valid};
			if (w.bus_err) exp_s = 32'h800;
			if (hit(0, a.laddr, a.priv) || hit(1, a.laddr, a.priv) || hit(2, a.laddr, a.priv)
				|| hit(3, a.laddr, a.priv)) exp_s = 32'h3;
			rd(mtc_pkg::ADDR_PROBE_STATUS, exp_s, pg ? 32'hffffefff : 32'hffffffff);
		end
		end_sim();
	end
endmodule
`default_nettype wire
